/* File: pkg/sit_pkg.sv */
`default_nettype none
package sit_pkg;
  localparam logic [6:0] DEV_ADDR_FLOAT = 7'h12;
  localparam logic [6:0] DEV_ADDR_GND = 7'h13;
  localparam logic [6:0] DEV_ADDR_VCC = 7'h14;
  localparam logic [15:0] REG_IRQ_SRC = 16'hF080;
  localparam logic [15:0] REG_IRQ_EN = 16'hF084;
  localparam logic [15:0] REG_STEP = 16'h0004;
  localparam logic [31:0] IRQ_SRC_RESET = 32'h00000000;
  localparam logic [31:0] IRQ_EN_RESET = 32'h00000008;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  localparam int SRC_SCAN = 0;
  localparam int SRC_CAL = 1;
  localparam int SRC_APPROACH = 2;
  localparam int SRC_INIT = 3;
  localparam int CORE_CLK_HZ = 40000000;
  localparam int INIT_TIME_MS = 20;
  localparam int INIT_CYCLES = CORE_CLK_HZ / 1000 * INIT_TIME_MS;
  localparam int BYTE_BITS = 8;
  localparam int WORD_BYTES = 4;

  typedef enum logic [1:0] {
    REQ_READ,
    REQ_WR_ONE,
    REQ_WR_MORE,
    REQ_WR_WORD
  } sit_req_kind_t;

  typedef enum logic [2:0] {
    LK_ADDR,
    LK_REGHI,
    LK_REGLO,
    LK_WRITE,
    LK_READ,
    LK_IGNORE
  } sit_link_phase_t;
endpackage : sit_pkg
`default_nettype wire

/* File: pkg/sit_req_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sit_req_if;
  import sit_pkg::*;
  logic tgl;
  sit_req_kind_t kind;
  logic [15:0] addr;
  logic [31:0] data;
  modport tx (output tgl, kind, addr, data);
  modport rx (input tgl, kind, addr, data);
endinterface : sit_req_if
`default_nettype wire

/* File: rtl/sit_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module sit_sync2 #(
  parameter int W = 1 // Number of independent level bits.
) (
  input wire logic clk, // Destination clock.
  input wire logic rstN, // Asynchronous reset, active low.
  input wire logic [W-1:0] d, // Levels from another domain.
  output logic [W-1:0] q // Synchronised levels.
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  if (W < 1) begin : g_bad_width
    $error("sit_sync2 needs W of at least one");
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule : sit_sync2
`default_nettype wire

/* File: rtl/sit_req_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module sit_req_rx (
  input wire logic clk, // Core clock.
  input wire logic rstN, // Synchronised reset, active low.
  sit_req_if.rx req, // Request bundle from the link domain.
  output logic valid, // One-cycle pulse per request.
  output var sit_pkg::sit_req_kind_t kind, // Request kind.
  output logic [15:0] addr, // Register address.
  output logic [31:0] data // Write data.
);
  import sit_pkg::*;
  logic tglSync;
  logic tglSeen_ff;
  logic valid_ff;
  sit_req_kind_t kind_ff;
  logic [15:0] addr_ff;
  logic [31:0] data_ff;

  sit_sync2 #(.W(1)) uTglSync (
    .clk(clk),
    .rstN(rstN),
    .d(req.tgl),
    .q(tglSync)
  );

  // The payload is held still by the sender for many link bits, so it is safe to take it
  // once the toggle has come through the synchroniser.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tglSeen_ff <= 1'h0;
      valid_ff <= 1'h0;
      kind_ff <= REQ_READ;
      addr_ff <= 16'h0000;
      data_ff <= 32'h00000000;
    end else begin
      tglSeen_ff <= tglSync;
      valid_ff <= tglSync ^ tglSeen_ff;
      if (tglSync ^ tglSeen_ff) begin
        kind_ff <= req.kind;
        addr_ff <= req.addr;
        data_ff <= req.data;
      end
    end
  end

  assign valid = valid_ff;
  assign kind = kind_ff;
  assign addr = addr_ff;
  assign data = data_ff;
endmodule : sit_req_rx
`default_nettype wire

/* File: rtl/sit_target.sv */
`timescale 1ns/1ps
`default_nettype none
module sit_target #(
  parameter int INIT_WAIT = sit_pkg::INIT_CYCLES // Core cycles of initialisation.
) (
  input wire logic core_clk, // Core clock, 40 MHz.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic sclClk, // Serial clock pin, clock of the link logic.
  input wire logic sdaIn, // Serial data pin level.
  output logic sdaOut, // Serial data drive value, always low.
  output logic sdaOe, // High while the data pin is pulled low.
  output logic irqOutN, // Interrupt pin drive value, always low.
  output logic irqOutNOe, // High while the interrupt pin is pulled low.
  input wire logic addrStrapSensePinHigh, // Strap pin seen tied to supply.
  input wire logic addrStrapSensePinLow, // Strap pin seen tied to ground.
  output logic senseElectrodeEn, // High when the strap pin is free for sensing.
  output logic initDone, // High once initialisation is over.
  input wire logic eventScan, // Scan finished, one-cycle pulse.
  input wire logic eventCalDone, // Calibration finished, one-cycle pulse.
  input wire logic eventApproach // Body approach seen, one-cycle pulse.
);
  import sit_pkg::*;

  localparam int CNT_W = $clog2(INIT_WAIT + 1);
  localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_WAIT - 1);
  localparam logic [3:0] BIT_LAST = 4'(BYTE_BITS - 1);
  localparam logic [3:0] BIT_ACK = 4'(BYTE_BITS);
  localparam logic [1:0] IDX_LAST = 2'(WORD_BYTES - 1);

  if (INIT_WAIT < 1) begin : g_bad_init
    $error("sit_target needs INIT_WAIT of at least one");
  end

  logic rstMeta_ff;
  logic rstSyncN_ff;
  logic sclS;
  logic sdaS;
  logic sclPrev_ff;
  logic sdaPrev_ff;
  logic busStart;
  logic busStop;
  logic linkHold_ff;
  logic busOpen_ff;
  logic [CNT_W-1:0] initCnt_ff;
  logic initDone_ff;
  logic initEvt;
  logic strapHi;
  logic strapLo;
  logic [6:0] devAddr_ff;
  logic senseEn_ff;
  logic reqValid;
  sit_req_kind_t reqKind;
  logic [15:0] reqAddr;
  logic [31:0] reqData;
  logic pendOne_ff;
  logic [15:0] pendAddr_ff;
  logic [7:0] pendByte_ff;
  logic wrEn;
  logic [15:0] wrAddr;
  logic [31:0] wrData;
  logic [31:0] interrupt_source_flags_ff;
  logic [31:0] interrupt_enable_mask_ff;
  logic [31:0] srcEvt;
  logic clrSrc;
  logic [31:0] readWord_ff;
  logic irqOe_ff;
  logic sdaOut_ff;
  logic irqOutN_ff;
  logic initDoneL;
  sit_link_phase_t phase_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] rxShift_ff;
  logic ackPend_ff;
  logic [1:0] byteIdx_ff;
  logic [23:0] wAcc_ff;
  logic [15:0] regPtr_ff;
  logic reqTgl_ff;
  sit_req_kind_t reqKind_ff;
  logic [15:0] reqAddr_ff;
  logic [31:0] reqData_ff;
  logic [7:0] txByte_ff;
  logic sdaOe_ff;
  logic [7:0] byteNow;
  logic [7:0] wordByte;
  logic hostAck;
  logic lastByte;
  logic addrHit;

  sit_req_if reqBus();

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_ff <= 1'h0;
      rstSyncN_ff <= 1'h0;
    end else begin
      rstMeta_ff <= 1'h1;
      rstSyncN_ff <= rstMeta_ff;
    end
  end

  sit_sync2 #(.W(2)) uPinSync (
    .clk(core_clk),
    .rstN(rstSyncN_ff),
    .d({sclClk, sdaIn}),
    .q({sclS, sdaS})
  );

  sit_sync2 #(.W(2)) uStrapSync (
    .clk(core_clk),
    .rstN(rstSyncN_ff),
    .d({addrStrapSensePinHigh, addrStrapSensePinLow}),
    .q({strapHi, strapLo})
  );

  always_ff @(posedge core_clk or negedge rstSyncN_ff) begin
    if (!rstSyncN_ff) begin
      sclPrev_ff <= 1'h0;
      sdaPrev_ff <= 1'h0;
    end else begin
      sclPrev_ff <= sclS;
      sdaPrev_ff <= sdaS;
    end
  end

  assign busStart = sclPrev_ff & sclS & sdaPrev_ff & ~sdaS;
  assign busStop = sclPrev_ff & sclS & ~sdaPrev_ff & sdaS;

  // Any data edge with the clock high resets the link logic, so a stray change in the
  // middle of a byte drops the transfer; a start releases it once the clock is low again.
  always_ff @(posedge core_clk or negedge rstSyncN_ff) begin
    if (!rstSyncN_ff) begin
      linkHold_ff <= 1'h1;
      busOpen_ff <= 1'h0;
    end else if (busStart) begin
      linkHold_ff <= 1'h1;
      busOpen_ff <= 1'h1;
    end else if (busStop) begin
      linkHold_ff <= 1'h1;
      busOpen_ff <= 1'h0;
    end else if (busOpen_ff && !sclS) begin
      linkHold_ff <= 1'h0;
    end
  end

  assign initEvt = !initDone_ff && (initCnt_ff == INIT_LAST);

  always_ff @(posedge core_clk or negedge rstSyncN_ff) begin
    if (!rstSyncN_ff) begin
      initCnt_ff <= '0;
      initDone_ff <= 1'h0;
      devAddr_ff <= DEV_ADDR_FLOAT;
      senseEn_ff <= 1'h0;
    end else if (initEvt) begin
      initDone_ff <= 1'h1;
      senseEn_ff <= !strapHi && !strapLo;
      if (strapHi) begin
        devAddr_ff <= DEV_ADDR_VCC;
      end else if (strapLo) begin
        devAddr_ff <= DEV_ADDR_GND;
      end else begin
        devAddr_ff <= DEV_ADDR_FLOAT;
      end
    end else if (!initDone_ff) begin
      initCnt_ff <= initCnt_ff + CNT_W'(1);
    end
  end

  sit_req_rx uReqRx (
    .clk(core_clk),
    .rstN(rstSyncN_ff),
    .req(reqBus),
    .valid(reqValid),
    .kind(reqKind),
    .addr(reqAddr),
    .data(reqData)
  );

  // A lone data byte is only known to be lone when the transfer ends, so it is parked here.
  always_ff @(posedge core_clk or negedge rstSyncN_ff) begin
    if (!rstSyncN_ff) begin
      pendOne_ff <= 1'h0;
      pendAddr_ff <= 16'h0000;
      pendByte_ff <= 8'h00;
    end else if (reqValid) begin
      pendOne_ff <= (reqKind == REQ_WR_ONE);
      pendAddr_ff <= reqAddr;
      pendByte_ff <= reqData[7:0];
    end else if (busStart || busStop) begin
      pendOne_ff <= 1'h0;
    end
  end

  always_comb begin
    wrEn = 1'h0;
    wrAddr = reqAddr;
    wrData = reqData;
    if (reqValid && (reqKind == REQ_WR_WORD)) begin
      wrEn = 1'h1;
    end else if ((busStart || busStop) && pendOne_ff) begin
      wrEn = 1'h1;
      wrAddr = pendAddr_ff;
      wrData = {interrupt_enable_mask_ff[31:8], pendByte_ff};
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN_ff) begin
    if (!rstSyncN_ff) begin
      interrupt_enable_mask_ff <= IRQ_EN_RESET;
    end else if (wrEn && (wrAddr == REG_IRQ_EN)) begin
      interrupt_enable_mask_ff <= wrData;
    end
  end

  assign clrSrc = reqValid && (reqKind == REQ_READ) && (reqAddr == REG_IRQ_SRC);

  always_comb begin
    srcEvt = 32'h00000000;
    srcEvt[SRC_SCAN] = eventScan;
    srcEvt[SRC_CAL] = eventCalDone;
    srcEvt[SRC_APPROACH] = eventApproach;
    srcEvt[SRC_INIT] = initEvt;
  end

  // An event in the same cycle as the clearing read survives into the next read.
  always_ff @(posedge core_clk or negedge rstSyncN_ff) begin
    if (!rstSyncN_ff) begin
      interrupt_source_flags_ff <= IRQ_SRC_RESET;
    end else begin
      interrupt_source_flags_ff <= (interrupt_source_flags_ff & ~{32{clrSrc}}) | srcEvt;
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN_ff) begin
    if (!rstSyncN_ff) begin
      readWord_ff <= UNMAPPED_READ;
    end else if (reqValid && (reqKind == REQ_READ)) begin
      if (reqAddr == REG_IRQ_SRC) begin
        readWord_ff <= interrupt_source_flags_ff;
      end else if (reqAddr == REG_IRQ_EN) begin
        readWord_ff <= interrupt_enable_mask_ff;
      end else begin
        readWord_ff <= UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN_ff) begin
    if (!rstSyncN_ff) begin
      irqOe_ff <= 1'h0;
      sdaOut_ff <= 1'h0;
      irqOutN_ff <= 1'h0;
    end else begin
      irqOe_ff <= |(interrupt_source_flags_ff & interrupt_enable_mask_ff);
      sdaOut_ff <= 1'h0;
      irqOutN_ff <= 1'h0;
    end
  end

  sit_sync2 #(.W(1)) uInitSyncL (
    .clk(sclClk),
    .rstN(rstSyncN_ff),
    .d(initDone_ff),
    .q(initDoneL)
  );

  // The device address settles with initDone, ahead of its synchronised copy initDoneL, so it needs no synchroniser.
  assign byteNow = {rxShift_ff[6:0], sdaIn};
  assign hostAck = !sdaIn;
  assign lastByte = (byteIdx_ff == IDX_LAST);
  assign addrHit = initDoneL && (byteNow[7:1] == devAddr_ff);
  assign wordByte = readWord_ff[(WORD_BYTES - 1 - byteIdx_ff) * BYTE_BITS +: BYTE_BITS];

  always_ff @(posedge sclClk or posedge linkHold_ff) begin
    if (linkHold_ff) begin
      phase_ff <= LK_ADDR;
      bitCnt_ff <= 4'h0;
      rxShift_ff <= 8'h00;
      ackPend_ff <= 1'h0;
      byteIdx_ff <= 2'h0;
      wAcc_ff <= 24'h000000;
    end else if (bitCnt_ff != BIT_ACK) begin
      bitCnt_ff <= bitCnt_ff + 4'h1;
      rxShift_ff <= byteNow;
      if (bitCnt_ff == BIT_LAST) begin
        unique case (phase_ff)
          LK_ADDR: begin
            ackPend_ff <= addrHit;
          end
          LK_REGHI, LK_REGLO: begin
            ackPend_ff <= 1'h1;
          end
          LK_WRITE: begin
            ackPend_ff <= 1'h1;
            wAcc_ff <= {wAcc_ff[15:0], byteNow};
          end
          default: begin
            ackPend_ff <= 1'h0;
          end
        endcase
      end
    end else begin
      bitCnt_ff <= 4'h0;
      ackPend_ff <= 1'h0;
      unique case (phase_ff)
        LK_ADDR: begin
          if (!ackPend_ff) begin
            phase_ff <= LK_IGNORE;
          end else if (rxShift_ff[0]) begin
            phase_ff <= LK_READ;
          end else begin
            phase_ff <= LK_REGHI;
          end
        end
        LK_REGHI: begin
          phase_ff <= LK_REGLO;
        end
        LK_REGLO: begin
          phase_ff <= LK_WRITE;
        end
        LK_WRITE: begin
          byteIdx_ff <= byteIdx_ff + 2'h1;
        end
        LK_READ: begin
          if (!hostAck) begin
            phase_ff <= LK_IGNORE;
          end else begin
            byteIdx_ff <= byteIdx_ff + 2'h1;
          end
        end
        default: begin
          phase_ff <= LK_IGNORE;
        end
      endcase
    end
  end

  // The register pointer and the request toggle outlive starts and stops, so they use the
  // main reset; a pointer written before a repeated start is then used by the read.
  always_ff @(posedge sclClk or negedge rstSyncN_ff) begin
    if (!rstSyncN_ff) begin
      regPtr_ff <= 16'h0000;
      reqTgl_ff <= 1'h0;
      reqKind_ff <= REQ_READ;
      reqAddr_ff <= 16'h0000;
      reqData_ff <= 32'h00000000;
    end else if (bitCnt_ff == BIT_LAST) begin
      unique case (phase_ff)
        LK_ADDR: begin
          if (addrHit && sdaIn) begin
            reqTgl_ff <= ~reqTgl_ff;
            reqKind_ff <= REQ_READ;
            reqAddr_ff <= regPtr_ff;
          end
        end
        LK_REGHI: begin
          regPtr_ff[15:8] <= byteNow;
        end
        LK_REGLO: begin
          regPtr_ff[7:0] <= byteNow;
        end
        LK_WRITE: begin
          reqTgl_ff <= ~reqTgl_ff;
          reqAddr_ff <= regPtr_ff;
          reqData_ff <= {wAcc_ff, byteNow};
          if (lastByte) begin
            reqKind_ff <= REQ_WR_WORD;
            regPtr_ff <= regPtr_ff + REG_STEP;
          end else if (byteIdx_ff == 2'h0) begin
            reqKind_ff <= REQ_WR_ONE;
          end else begin
            reqKind_ff <= REQ_WR_MORE;
          end
        end
        default: begin
        end
      endcase
    end else if ((bitCnt_ff == BIT_ACK) && (phase_ff == LK_READ) && hostAck && lastByte) begin
      reqTgl_ff <= ~reqTgl_ff;
      reqKind_ff <= REQ_READ;
      reqAddr_ff <= regPtr_ff + REG_STEP;
      regPtr_ff <= regPtr_ff + REG_STEP;
    end
  end

  assign reqBus.tgl = reqTgl_ff;
  assign reqBus.kind = reqKind_ff;
  assign reqBus.addr = reqAddr_ff;
  assign reqBus.data = reqData_ff;

  // The data line only ever moves on a falling clock edge, half a bit away from sampling.
  // The clock pin is only an input: the block never stretches the clock.
  always_ff @(negedge sclClk or posedge linkHold_ff) begin
    if (linkHold_ff) begin
      txByte_ff <= 8'h00;
      sdaOe_ff <= 1'h0;
    end else if (bitCnt_ff == BIT_ACK) begin
      sdaOe_ff <= ackPend_ff;
    end else if (phase_ff == LK_READ) begin
      if (bitCnt_ff == 4'h0) begin
        txByte_ff <= {wordByte[6:0], 1'h0};
        sdaOe_ff <= ~wordByte[7];
      end else begin
        txByte_ff <= {txByte_ff[6:0], 1'h0};
        sdaOe_ff <= ~txByte_ff[7];
      end
    end else begin
      sdaOe_ff <= 1'h0;
    end
  end

  assign sdaOut = sdaOut_ff;
  assign sdaOe = sdaOe_ff;
  assign irqOutN = irqOutN_ff;
  assign irqOutNOe = irqOe_ff;
  assign senseElectrodeEn = senseEn_ff;
  assign initDone = initDone_ff;
endmodule : sit_target
`default_nettype wire

/* File: tb/sit_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sit_props #(
  parameter int INIT_WAIT = 20 // Core cycles of initialisation.
) (
  input wire logic core_clk, // Core clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic sclClk, // Serial clock.
  input wire logic sdaIn, // Data wire.
  input wire logic sdaOut, // Data drive value.
  input wire logic sdaOe, // Data pull enable.
  input wire logic irqOutN, // Interrupt drive value.
  input wire logic irqOutNOe, // Interrupt pull enable.
  input wire logic addrStrapSensePinHigh, // Strap at supply.
  input wire logic addrStrapSensePinLow, // Strap at ground.
  input wire logic senseElectrodeEn, // Strap pin free for sensing.
  input wire logic initDone, // Initialisation over.
  input wire logic eventScan, // Scan event.
  input wire logic eventCalDone, // Calibration event.
  input wire logic eventApproach // Approach event.
);
  int waitCnt_ff;
  // Counts from the raw release; the design's own two-flop release only adds cycles.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt_ff <= 0;
    end else if (waitCnt_ff < INIT_WAIT) begin
      waitCnt_ff <= waitCnt_ff + 1;
    end
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  chk_sda_open_drain: assert property (sdaOut == 1'b0)
    else $error("data pin driven high");
  chk_irq_open_drain: assert property (irqOutN == 1'b0)
    else $error("interrupt pin driven high");
  chk_irq_after_init: assert property (!initDone |-> !irqOutNOe)
    else $error("interrupt before init");
  chk_init_raises_irq: assert property ($rose(initDone) |=> irqOutNOe)
    else $error("no interrupt after init");
  chk_init_wait_time: assert property ($rose(initDone) |-> waitCnt_ff == INIT_WAIT)
    else $error("init too early");
  chk_irq_has_cause: assert property ($rose(irqOutNOe) |->
    $past(eventScan || eventCalDone || eventApproach, 2) || !$past(initDone, 2) || sclClk)
    else $error("interrupt without cause");
  chk_sense_strapped: assert property (initDone &&
    (addrStrapSensePinHigh || addrStrapSensePinLow) |-> !senseElectrodeEn)
    else $error("strapped pin used for sensing");
  chk_sense_pre_init: assert property (!initDone |-> !senseElectrodeEn)
    else $error("sensing before init");
  chk_sense_floating: assert property ($rose(initDone) && !addrStrapSensePinHigh &&
    !addrStrapSensePinLow |-> ##[0:3] senseElectrodeEn)
    else $error("floating pin not freed");
  chk_sda_low_phase: assert property ($rose(sdaOe) || $fell(sdaOe) |-> !sclClk)
    else $error("data changed while clock high");
  chk_ack_stands: assert property ($rose(sdaOe) |-> sdaOe [*3])
    else $error("data pull too short");
  cover property ($rose(irqOutNOe));
  cover property ($rose(sdaOe));
  cover property ($rose(senseElectrodeEn));
endmodule : sit_props
bind sit_target sit_props #(.INIT_WAIT(INIT_WAIT)) props (.core_clk, .rst_b, .sclClk,
  .sdaIn, .sdaOut, .sdaOe, .irqOutN, .irqOutNOe, .addrStrapSensePinHigh,
  .addrStrapSensePinLow, .senseElectrodeEn, .initDone, .eventScan, .eventCalDone,
  .eventApproach);
`default_nettype wire

/* File: tb/sit_host_bfm.sv */
`timescale 1ns/1ps
`default_nettype none
module sit_host_bfm (
  output logic scl, // Serial clock, high between frames.
  output logic sdaPull, // High while the host pulls data low.
  input wire logic sda // Resolved data wire.
);
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  // A long high phase on bit 0 and on the acknowledge gives the core time to
  // commit or fetch a word before the next falling edge.
  task automatic clk_bit(input logic b, input int hi, output logic r);
    #10 sdaPull = ~b;
    #30 scl = 1'b1;
    r = sda;
    #(hi) scl = 1'b0;
  endtask : clk_bit
  task automatic start();
    #10 sdaPull = 1'b0;
    #30 scl = 1'b1;
    #200 sdaPull = 1'b1;
    #200 scl = 1'b0;
    // The link logic only leaves its hold once the core has seen the clock low, so the
    // first bit after a start must wait for that.
    #200;
  endtask : start
  task automatic stop();
    #10 sdaPull = 1'b1;
    #30 scl = 1'b1;
    #200 sdaPull = 1'b0;
    #400;
  endtask : stop
  task automatic xfer(input logic [7:0] tx, input logic hostAck, output logic [7:0] rx,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], (i == 0) ? 200 : 40, r);
      rx[i] = r;
    end
    clk_bit(~hostAck, 200, r);
    ack = ~r;
  endtask : xfer
endmodule : sit_host_bfm
`default_nettype wire

/* File: tb/sit_target_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sit_target_tb;
  import sit_pkg::*;
  localparam int INIT_W = 20;
  localparam int LIMIT = 30000;
  logic core_clk, rst_b, strapHi, strapLo, evScan, evCal, evApp;
  logic scl, hostPull, sdaOe, irqOe, sense, initDone, ack;
  logic [7:0] rx;
  logic [31:0] rdBuf [2];
  int fail_count, check_count, cycles;
  wire logic sda = ~(sdaOe | hostPull);
  sit_target #(.INIT_WAIT(INIT_W)) uut (.core_clk(core_clk), .rst_b(rst_b), .sclClk(scl),
    .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .irqOutN(), .irqOutNOe(irqOe),
    .addrStrapSensePinHigh(strapHi), .addrStrapSensePinLow(strapLo),
    .senseElectrodeEn(sense), .initDone(initDone), .eventScan(evScan),
    .eventCalDone(evCal), .eventApproach(evApp));
  sit_host_bfm host (.scl(scl), .sdaPull(hostPull), .sda(sda));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp, input string m);
    chk_word({31'h0, got}, {31'h0, exp}, m);
  endtask : chk_bit
  task automatic do_reset(input logic hi, input logic lo);
    rst_b = 1'b0;
    strapHi = hi;
    strapLo = lo;
    repeat (20) @(posedge core_clk);
    chk_bit(irqOe, 1'b0, "irq in reset");
    #2 rst_b = 1'b1;
    for (int i = 0; i < INIT_W + 10 && initDone !== 1'b1; i++) begin
      #25;
    end
    chk_bit(initDone, 1'b1, "init done");
    #50 chk_bit(irqOe, 1'b1, "irq after init");
    // The link side learns of init only from serial clock edges, so one frame is spent.
    host.start();
    host.xfer(8'h00, 1'b0, rx, ack);
    host.stop();
  endtask : do_reset
  task automatic hdr(input logic [6:0] dev, input logic [15:0] a);
    host.start();
    host.xfer({dev, 1'b0}, 1'b0, rx, ack);
    host.xfer(a[15:8], 1'b0, rx, ack);
    host.xfer(a[7:0], 1'b0, rx, ack);
  endtask : hdr
  task automatic wr(input logic [15:0] a, input logic [63:0] d, input int nb);
    hdr(DEV_ADDR_FLOAT, a);
    for (int i = 0; i < nb; i++) begin
      host.xfer(d[63 - 8 * i -: 8], 1'b0, rx, ack);
    end
    chk_bit(ack, 1'b1, "write ack");
    host.stop();
  endtask : wr
  task automatic rd(input logic [15:0] a, input int nw, input logic fmtB);
    if (fmtB) begin
      hdr(DEV_ADDR_FLOAT, a);
    end
    host.start();
    host.xfer({DEV_ADDR_FLOAT, 1'b1}, 1'b0, rx, ack);
    for (int i = 0; i < 4 * nw; i++) begin
      host.xfer(8'hFF, i != 4 * nw - 1, rx, ack);
      rdBuf[i / 4] = {rdBuf[i / 4][23:0], rx};
    end
    host.stop();
  endtask : rd
  task automatic t_strap();
    logic [6:0] adr [3];
    adr = '{DEV_ADDR_FLOAT, DEV_ADDR_GND, DEV_ADDR_VCC};
    for (int k = 0; k < 3; k++) begin
      do_reset(k == 2, k == 1);
      chk_bit(sense, k == 0, "sense enable");
      for (int j = 0; j < 3; j++) begin
        host.start();
        host.xfer({adr[j], 1'b0}, 1'b0, rx, ack);
        host.stop();
        chk_bit(ack, j == k, "address match");
      end
    end
    do_reset(1'b0, 1'b0);
    $display("test strap done");
  endtask : t_strap
  task automatic t_clear();
    rd(REG_IRQ_SRC, 1, 1'b1);
    chk_word(rdBuf[0], 32'h1 << SRC_INIT, "init source");
    chk_bit(irqOe, 1'b0, "irq cleared");
    rd(REG_IRQ_SRC, 1, 1'b1);
    chk_word(rdBuf[0], IRQ_SRC_RESET, "source after read");
    $display("test clear done");
  endtask : t_clear
  task automatic t_cont();
    // The first word hits the read-only source and is dropped; the second lands one up.
    wr(REG_IRQ_SRC, 64'hFFFFFFFF12340006, 8);
    rd(REG_IRQ_EN, 2, 1'b1);
    chk_word(rdBuf[0], 32'h12340006, "enable word");
    chk_word(rdBuf[1], UNMAPPED_READ, "unmapped word");
    $display("test continuous done");
  endtask : t_cont
  task automatic t_events();
    @(posedge core_clk) #2 evScan = 1'b1;
    @(posedge core_clk) #2 evScan = 1'b0;
    repeat (3) @(posedge core_clk);
    #2 chk_bit(irqOe, 1'b0, "masked source");
    evCal = 1'b1;
    evApp = 1'b1;
    @(posedge core_clk) #2 evCal = 1'b0;
    evApp = 1'b0;
    repeat (2) @(posedge core_clk);
    #2 chk_bit(irqOe, 1'b1, "enabled source");
    rd(REG_IRQ_SRC, 1, 1'b1);
    chk_word(rdBuf[0], (32'h1 << SRC_SCAN) | (32'h1 << SRC_CAL) | (32'h1 << SRC_APPROACH),
      "event flags");
    chk_bit(irqOe, 1'b0, "irq after read");
    $display("test events done");
  endtask : t_events
  task automatic t_single_abort();
    logic b;
    wr(REG_IRQ_EN, 64'hA500000000000000, 1);
    hdr(DEV_ADDR_FLOAT, REG_IRQ_EN);
    for (int i = 0; i < 3; i++) begin
      host.xfer(8'h5A, 1'b0, rx, ack);
    end
    for (int i = 0; i < 4; i++) begin
      host.clk_bit(1'b0, 40, b);
    end
    host.start();
    host.stop();
    rd(REG_IRQ_EN, 1, 1'b1);
    chk_word(rdBuf[0], 32'h123400A5, "single byte kept");
    $display("test single and abort done");
  endtask : t_single_abort
  task automatic t_nack();
    hdr(DEV_ADDR_FLOAT, REG_IRQ_EN);
    host.stop();
    host.start();
    host.xfer({DEV_ADDR_FLOAT, 1'b1}, 1'b0, rx, ack);
    host.xfer(8'hFF, 1'b0, rx, ack);
    chk_word({24'h0, rx}, 32'h00000012, "first byte");
    #5 chk_bit(sdaOe, 1'b0, "released after nack");
    host.stop();
    rd(16'h0000, 1, 1'b0);
    chk_word(rdBuf[0], 32'h123400A5, "direct read");
    $display("test nack done");
  endtask : t_nack
  initial begin
    rst_b = 1'b0;
    strapHi = 1'b0;
    strapLo = 1'b0;
    evScan = 1'b0;
    evCal = 1'b0;
    evApp = 1'b0;
    t_strap();
    t_clear();
    t_cont();
    t_events();
    t_single_abort();
    t_nack();
    tally_and_finish();
  end
endmodule : sit_target_tb
`default_nettype wire
